/* verilog/fsrc_regs.vh */
`ifndef FSRC_REGS_VH
`define FSRC_REGS_VH

// ****************************************
// Frame lengths and readback timing
// ****************************************
`define FSRC_FRAME_PLAIN    5'h10
`define FSRC_FRAME_CHECKED  5'h18
`define FSRC_READ_ARM_BITS  5'h04
`define FSRC_SDO_START_RISE 5'h05
`define FSRC_CRC_POLY       8'h07
`define FSRC_CRC_INIT       8'h00

// ****************************************
// Readback status word fields
// ****************************************
`define FSRC_RB_ADDR_HI     15
`define FSRC_RB_ADDR_LO     13
`define FSRC_RB_ONE         12
`define FSRC_RB_ZERO        11
`define FSRC_RB_RANGE_HI    10
`define FSRC_RB_RANGE_LO    7
`define FSRC_RB_CLEAR_SEL   6
`define FSRC_RB_OUT_EN      5
`define FSRC_RB_SENSE       4
`define FSRC_RB_CRC_ERR     3
`define FSRC_RB_OVERTEMP    2
`define FSRC_RB_LOOP_FAULT  1
`define FSRC_RB_VOLT_FAULT  0

// ****************************************
// Serial control word fields
// ****************************************
`define FSRC_WR_RW          12
`define FSRC_WR_CLEAR       3
`define FSRC_WR_RESET       2

// ****************************************
// Reset values
// ****************************************
`define FSRC_RST_RANGE      4'h0
`define FSRC_RST_CLEAR_SEL  1'b0
`define FSRC_RST_OUT_EN     1'b0
`define FSRC_RST_SENSE      1'b1
`define FSRC_RST_CLEAR      1'b0

// ****************************************
// Overrange current range codes
// ****************************************
`define FSRC_RANGE_OVR_4_20 4'hd
`define FSRC_RANGE_OVR_0_20 4'he
`define FSRC_RANGE_OVR_0_24 4'hf

`endif

/* verilog/fsrc_sync.v */
`timescale 1ns/100ps

module fsrc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // ****************************************
  // Two flops per bit; only stage two is read
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (sys_rst) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* verilog/fsrc_crc8.v */
`timescale 1ns/100ps
`include "fsrc_regs.vh"

module fsrc_crc8 (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Bit stream
  input  wire       restart,
  input  wire       bit_valid,
  input  wire       bit_in,
  // Remainder
  output reg  [7:0] remainder
);

  wire       feedback;
  wire [7:0] shifted;

  // Serial division, MSB first; zero remainder means the frame checks
  assign feedback = remainder[7] ^ bit_in;
  assign shifted  = {remainder[6:0], 1'b0} ^ (feedback ? `FSRC_CRC_POLY : 8'h00);

  always @(posedge clk) begin
    if (sys_rst || restart) begin
      remainder <= `FSRC_CRC_INIT;
    end else if (bit_valid) begin
      remainder <= shifted;
    end
  end

endmodule

/* verilog/fsrc_top.v */
// Function
// - Read needs matching address and read bit
// - Data out idle off; drive from fifth rise
// - Frame sync rise turns data out off
// - One read returns settings and faults
// - Fixed readback word field layout
// - Four status bits, read only
// - Failed CRC-8 sets packet error
// - Hot core sets overtemperature bit
// - Low output headroom sets current fault
// - Voltage output short sets voltage fault
// - Software mode: any fault pulls alarm
// - Hardware mode: no status, three alarms
// - Each hardware alarm follows its fault
// - Clear high; select is pin OR bit, pin only in hardware mode
// - Select picks zero or midscale
// - After clear, programmed value returns
// - Serial clear bit also clears in software mode
// - Serial bit selects sense resistor in software mode
// - Overrange only on three current ranges
// - Checked frame written only if CRC passes
// - Status read clears packet error
`timescale 1ns/100ps
`include "fsrc_regs.vh"

module fsrc_top (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Serial link pins
  input  wire       sclk,
  input  wire       sync_n,
  input  wire       sdin,
  output reg        sdo,
  output reg        sdo_oe,
  // Straps and control pins
  input  wire [2:0] device_address_bits,
  input  wire       hardware_mode_pin,
  input  wire [3:0] range_pins,
  input  wire       sense_select_pin,
  input  wire       clear_pin,
  input  wire       clear_value_select_pin,
  // Analog fault detectors
  input  wire       loop_open_det,
  input  wire       volt_short_det,
  input  wire       overtemp_det,
  // Open-drain alarm pins
  output reg        fault_alarm_n,
  output reg        fault_alarm_oe,
  output reg        loop_open_alarm_n,
  output reg        loop_open_alarm_oe,
  output reg        volt_short_alarm_n,
  output reg        volt_short_alarm_oe,
  output reg        temp_alarm_n,
  output reg        temp_alarm_oe,
  // Output stage control
  output reg [3:0]  range_code,
  output reg        sense_resistor_select,
  output reg        output_enable_bit,
  output reg        clear_active,
  output reg        clear_to_midscale,
  output reg        overrange_sense_sel
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire [16:0] pins_s;
  wire        sclk_s;
  wire        frame_s;
  wire        sync_n_s;
  wire        sdin_s;
  wire [2:0]  addr_s;
  wire        hw_mode_s;
  wire [3:0]  range_pins_s;
  wire        sense_pin_s;
  wire        clear_pin_s;
  wire        clear_sel_pin_s;
  wire        loop_open_s;
  wire        volt_short_s;
  wire        temp_s;

  fsrc_sync #(
    .WIDTH    (17)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({sclk, ~sync_n, sdin, device_address_bits, hardware_mode_pin,
                range_pins, sense_select_pin, clear_pin, clear_value_select_pin,
                loop_open_det, volt_short_det, overtemp_det}),
    .sync_out (pins_s)
  );

  // Frame sync passes inverted so the flops' reset level means idle, not a false frame end
  assign {sclk_s, frame_s, sdin_s, addr_s, hw_mode_s, range_pins_s, sense_pin_s,
          clear_pin_s, clear_sel_pin_s, loop_open_s, volt_short_s, temp_s} = pins_s;
  assign sync_n_s = ~frame_s;

  // ****************************************
  // Edge detection on the link
  // ****************************************
  reg  sclk_d;
  reg  sync_n_d;
  wire sclk_rise;
  wire sclk_fall;
  wire sync_rise;
  wire in_frame;

  always @(posedge clk) begin
    if (sys_rst) begin
      sclk_d   <= 1'b0;
      sync_n_d <= 1'b1;
    end else begin
      sclk_d   <= sclk_s;
      sync_n_d <= sync_n_s;
    end
  end

  assign in_frame  = ~sync_n_s;
  assign sclk_rise = sclk_s & ~sclk_d & in_frame;
  assign sclk_fall = ~sclk_s & sclk_d & in_frame;
  assign sync_rise = sync_n_s & ~sync_n_d;

  // ****************************************
  // Receive shift register and CRC
  // ****************************************
  reg  [23:0] rx_shift;
  reg  [4:0]  bit_cnt;
  reg  [4:0]  rise_cnt;
  wire [7:0]  crc_rem;
  wire [15:0] rx_word;

  fsrc_crc8 u_crc (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .restart   (sync_rise),
    .bit_valid (sclk_fall),
    .bit_in    (sdin_s),
    .remainder (crc_rem)
  );

  // Data sampled on falling SCLK; counters saturate so long frames are rejected
  always @(posedge clk) begin
    if (sys_rst || sync_rise) begin
      rx_shift <= 24'h00_0000;
      bit_cnt  <= 5'h00;
      rise_cnt <= 5'h00;
    end else begin
      if (sclk_fall) begin
        rx_shift <= {rx_shift[22:0], sdin_s};
        if (bit_cnt != 5'h1f) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
      if (sclk_rise && rise_cnt != 5'h1f) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  // Word sits in the top sixteen bits of a checked frame
  assign rx_word = (bit_cnt == `FSRC_FRAME_CHECKED) ? rx_shift[23:8] : rx_shift[15:0];

  // ****************************************
  // Frame decode
  // ****************************************
  wire addr_match;
  wire len_ok;
  wire crc_pass;
  wire write_ok;
  wire crc_fail;

  assign addr_match = rx_word[`FSRC_RB_ADDR_HI:`FSRC_RB_ADDR_LO] == addr_s;
  assign len_ok     = (bit_cnt == `FSRC_FRAME_PLAIN) || (bit_cnt == `FSRC_FRAME_CHECKED);
  assign crc_pass   = (bit_cnt == `FSRC_FRAME_PLAIN) || (crc_rem == 8'h00);
  assign write_ok   = sync_rise & len_ok & crc_pass & addr_match & ~hw_mode_s &
                      ~rx_word[`FSRC_WR_RW];
  assign crc_fail   = sync_rise & (bit_cnt == `FSRC_FRAME_CHECKED) & (crc_rem != 8'h00);

  // ****************************************
  // Control register
  // ****************************************
  reg [3:0] range_bits;
  reg       clear_sel_bit;
  reg       out_en_bit;
  reg       sense_bit;
  reg       sw_clear_bit;

  always @(posedge clk) begin
    if (sys_rst || (write_ok && rx_word[`FSRC_WR_RESET])) begin
      range_bits    <= `FSRC_RST_RANGE;
      clear_sel_bit <= `FSRC_RST_CLEAR_SEL;
      out_en_bit    <= `FSRC_RST_OUT_EN;
      sense_bit     <= `FSRC_RST_SENSE;
      sw_clear_bit  <= `FSRC_RST_CLEAR;
    end else if (write_ok) begin
      range_bits    <= rx_word[`FSRC_RB_RANGE_HI:`FSRC_RB_RANGE_LO];
      clear_sel_bit <= rx_word[`FSRC_RB_CLEAR_SEL];
      out_en_bit    <= rx_word[`FSRC_RB_OUT_EN];
      sense_bit     <= rx_word[`FSRC_RB_SENSE];
      sw_clear_bit <= rx_word[`FSRC_WR_CLEAR];
    end
  end

  // ****************************************
  // Status bits
  // ****************************************
  reg  crc_err;
  reg  read_done;
  wire next_crc_err;

  // Cleared after a read; a new failure wins over the clear
  assign next_crc_err = crc_fail | (crc_err & ~(sync_rise & read_done));

  always @(posedge clk) begin
    if (sys_rst) begin
      crc_err <= 1'b0;
    end else begin
      crc_err <= next_crc_err;
    end
  end

  // Only hardware sets these; host writes never reach them
  wire [15:0] status_word;

  // Settings and faults in one word
  assign status_word = {addr_s, 1'b1, 1'b0, range_bits, clear_sel_bit, out_en_bit, sense_bit,
                        crc_err, temp_s,
                        loop_open_s,
                        volt_short_s};

  // ****************************************
  // Readback shifter
  // ****************************************
  reg        read_armed;
  reg [15:0] tx_shift;

  always @(posedge clk) begin
    if (sys_rst) begin
      read_armed <= 1'b0;
      read_done  <= 1'b0;
      tx_shift   <= 16'h0000;
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
    end else if (sync_rise) begin
      // Release data out at frame end
      read_armed <= 1'b0;
      read_done  <= 1'b0;
      sdo_oe     <= 1'b0;
      sdo        <= 1'b0;
    end else begin
      // Address and read bit both needed; none in hardware mode
      if (sclk_fall && bit_cnt == `FSRC_READ_ARM_BITS - 5'h01 && ~hw_mode_s &&
          rx_shift[2:0] == addr_s && sdin_s) begin
        read_armed <= 1'b1;
      end
      if (sclk_rise && read_armed) begin
        // First bit on the fifth rise
        if (rise_cnt == `FSRC_SDO_START_RISE - 5'h01) begin
          sdo_oe    <= 1'b1;
          sdo       <= status_word[15];
          tx_shift  <= {status_word[14:0], 1'b0};
          read_done <= 1'b1;
        end else if (sdo_oe) begin
          sdo      <= tx_shift[15];
          tx_shift <= {tx_shift[14:0], 1'b0};
        end
      end
    end
  end

  // ****************************************
  // Alarm pins
  // ****************************************
  // Alarms assert by enabling the low drive; pull-up gives the high level
  always @(posedge clk) begin
    if (sys_rst) begin
      fault_alarm_n       <= 1'b0;
      fault_alarm_oe      <= 1'b0;
      loop_open_alarm_n   <= 1'b0;
      loop_open_alarm_oe  <= 1'b0;
      volt_short_alarm_n  <= 1'b0;
      volt_short_alarm_oe <= 1'b0;
      temp_alarm_n        <= 1'b0;
      temp_alarm_oe       <= 1'b0;
    end else begin
      fault_alarm_oe      <= ~hw_mode_s & (loop_open_s | volt_short_s | crc_err | temp_s);
      loop_open_alarm_oe  <= hw_mode_s & loop_open_s;
      volt_short_alarm_oe <= hw_mode_s & volt_short_s;
      temp_alarm_oe       <= hw_mode_s & temp_s;
    end
  end

  // ****************************************
  // Range selection and clear
  // ****************************************
  wire [3:0] eff_range;
  wire       eff_sense;

  // Pins override serial settings in hardware mode
  assign eff_range = hw_mode_s ? range_pins_s : range_bits;
  assign eff_sense = hw_mode_s ? sense_pin_s : sense_bit;

  always @(posedge clk) begin
    if (sys_rst) begin
      range_code            <= `FSRC_RST_RANGE;
      sense_resistor_select <= `FSRC_RST_SENSE;
      output_enable_bit     <= `FSRC_RST_OUT_EN;
      clear_active          <= 1'b0;
      clear_to_midscale     <= 1'b0;
      overrange_sense_sel   <= 1'b0;
    end else begin
      range_code            <= eff_range;
      sense_resistor_select <= eff_sense;
      output_enable_bit     <= hw_mode_s | out_en_bit;
      // Clear pin active high, also serial clear bit outside hardware mode
      // Dropping clear restores the latest programmed range
      clear_active          <= clear_pin_s | (sw_clear_bit & ~hw_mode_s);
      clear_to_midscale     <= clear_value_select_pin_or(clear_sel_pin_s, clear_sel_bit,
                                                         hw_mode_s);
      // Reduced resistor only on the three overrange current codes
      overrange_sense_sel   <= eff_sense & ((eff_range == `FSRC_RANGE_OVR_4_20) ||
                                           (eff_range == `FSRC_RANGE_OVR_0_20) ||
                                           (eff_range == `FSRC_RANGE_OVR_0_24));
    end
  end

  // Serial select bit is masked off in hardware mode, so only the pin selects there
  function clear_value_select_pin_or;
    input pin_sel;
    input bit_sel;
    input hw;
    begin
      clear_value_select_pin_or = pin_sel | (bit_sel & ~hw);
    end
  endfunction

endmodule

/* test/fsrc_top_sva.sv */
`timescale 1ns/100ps
module fsrc_top_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Serial link and control pins
  input wire logic       sync_n, sdo_oe, hardware_mode_pin, clear_pin, clear_value_select_pin,
  input wire logic [3:0] range_pins,
  // Fault detectors
  input wire logic       loop_open_det, volt_short_det, overtemp_det,
  // Alarm enables and settings
  input wire logic       fault_alarm_oe, loop_open_alarm_oe, volt_short_alarm_oe, temp_alarm_oe,
  input wire logic       clear_active, clear_to_midscale, overrange_sense_sel, output_enable_bit,
  input wire logic [3:0] range_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_oe_released: assert property ($rose(sync_n) |-> ##[3:5] !sdo_oe)
    else $error("data out still driven after frame end");
  a_oe_in_frame: assert property ($rose(sdo_oe) |-> !sync_n && !hardware_mode_pin)
    else $error("data out enabled outside a software read");
  a_sw_alarm: assert property ((!hardware_mode_pin && (loop_open_det || volt_short_det
    || overtemp_det))[*5] |-> fault_alarm_oe) else $error("alarm not pulled on fault");
  a_hw_loop: assert property ((hardware_mode_pin && loop_open_det)[*5] |-> loop_open_alarm_oe)
    else $error("loop alarm missing");
  a_hw_volt: assert property ((hardware_mode_pin && volt_short_det)[*5] |-> volt_short_alarm_oe)
    else $error("voltage alarm missing");
  a_hw_temp: assert property ((hardware_mode_pin && overtemp_det)[*5] |-> temp_alarm_oe)
    else $error("temperature alarm missing");
  a_loop_follows: assert property ((hardware_mode_pin && !loop_open_det)[*5]
    |-> !loop_open_alarm_oe) else $error("loop alarm held without fault");
  a_hw_no_status: assert property (hardware_mode_pin[*5] |-> !fault_alarm_oe)
    else $error("software alarm driven in hardware mode");
  a_clear_pin: assert property (clear_pin[*5] |-> clear_active)
    else $error("clear pin ignored");
  a_clear_or: assert property ((clear_pin && clear_value_select_pin)[*5]
    |-> clear_to_midscale) else $error("clear select pin not ORed in");
  a_hw_range: assert property ((hardware_mode_pin && $stable(range_pins))[*6]
    |-> range_code == range_pins && output_enable_bit) else $error("range pins not applied");
  a_ovr_ranges: assert property (!(range_code inside {4'hd, 4'he, 4'hf})[*2]
    |-> !overrange_sense_sel) else $error("overrange on a wrong range");
endmodule

bind fsrc_top fsrc_top_sva u_sva (.*);

/* test/fsrc_host.sv */
`timescale 1ns/100ps
module fsrc_host (
  // Serial link
  output logic      sclk = 1'b0,
  output logic      sync_n = 1'b1,
  output logic      sdin = 1'b0,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // Undriven data line has no pull, so it shows a changing level
  logic prev = 1'b0;

  // address and read bit lead the frame
  // frame sync rises only after all data
  task automatic xfer(input int n, input logic [23:0] w, output logic [15:0] rd,
                      output logic seen);
    logic b;
    rd = 16'h0000;
    seen = 1'b0;
    sync_n <= 1'b0;
    #62.5;
    for (int k = 1; k <= n; k++) begin
      b = sdo_oe ? sdo : ~prev;
      prev = b;
      seen |= sdo_oe;
      if (k > 5 && k < 22) rd[21-k] = b;
      sclk <= 1'b1;
      sdin <= w[24-k];
      #62.5;
      sclk <= 1'b0;
      #62.5;
    end
    sync_n <= 1'b1;
    #300;
  endtask
endmodule

/* test/fsrc_top_tb.sv */
`timescale 1ns/100ps
module fsrc_top_tb;
  logic        clk = 0, sys_rst = 1, hardware_mode_pin = 0, sense_select_pin = 1;
  logic        clear_pin = 0, clear_value_select_pin = 0;
  logic        loop_open_det = 0, volt_short_det = 0, overtemp_det = 0;
  logic [3:0]  range_pins = 4'h0;
  logic [2:0]  device_address_bits = 3'h5;
  wire         sclk, sync_n, sdin, sdo, sdo_oe, fault_alarm_oe, loop_open_alarm_oe;
  wire         volt_short_alarm_oe, temp_alarm_oe, clear_active, clear_to_midscale;
  wire         sense_resistor_select, output_enable_bit, overrange_sense_sel;
  wire  [3:0]  range_code;
  int          n_errors = 0, samples_checked = 0;
  logic [15:0] rd;
  logic        s;

  fsrc_top dut (.*, .fault_alarm_n(), .loop_open_alarm_n(), .volt_short_alarm_n(),
                .temp_alarm_n());
  fsrc_host host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo), .sdo_oe(sdo_oe));

  initial forever #4 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic wrw(input logic [15:0] d, input int n, input logic [7:0] flip);
    logic [15:0] r;
    logic        q;
    host.xfer(n, {d, crc8(d) ^ flip}, r, q);
  endtask

  task automatic rdw(input logic [2:0] a);
    logic [15:0] d;
    d = {a, 13'h1000};
    host.xfer(24, {d, crc8(d)}, rd, s);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    // Step off the edge so registered outputs have settled before they are read
    #1;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under this
  initial begin
    #300us;
    n_errors++;
    print_verdict;
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    wt(20);
    sys_rst <= 1'b0;
    wt(8);
    chk({range_code, sense_resistor_select, output_enable_bit, sdo_oe}, 16'h0004);
    $display("test reset finished");
    wrw({3'h5, 2'b00, 4'he, 3'b111, 4'h0}, 24, 8'h00);
    chk({range_code, output_enable_bit}, {4'he, 1'b1});
    @(posedge clk) {loop_open_det, overtemp_det} <= 2'b11;
    rdw(3'h5);
    chk(rd, {3'h5, 2'b10, 4'he, 3'b111, 4'b0110});
    chk(fault_alarm_oe, 1'b1);
    @(posedge clk) {loop_open_det, volt_short_det, overtemp_det} <= 3'b010;
    rdw(3'h5);
    chk(rd, {3'h5, 2'b10, 4'he, 3'b111, 4'b0001});
    $display("test status word finished");
    wrw({3'h2, 2'b00, 4'h1, 3'b111, 4'h0}, 16, 8'h00);
    chk(range_code, 4'he);
    rdw(3'h2);
    chk({s, sdo_oe}, 2'b00);
    $display("test wrong address finished");
    @(posedge clk) volt_short_det <= 1'b0;
    wrw({3'h5, 2'b00, 4'h5, 3'b011, 4'h0}, 24, 8'h01);
    chk({range_code, fault_alarm_oe}, {4'he, 1'b1});
    rdw(3'h5);
    chk(rd, {3'h5, 2'b10, 4'he, 3'b111, 4'b1000});
    rdw(3'h5);
    chk({rd[3:0], fault_alarm_oe, sdo_oe}, 6'h00);
    $display("test packet error finished");
    wrw({3'h5, 2'b00, 4'h6, 3'b000, 4'h8}, 16, 8'h00);
    chk({sense_resistor_select, clear_active, clear_to_midscale}, 3'b010);
    @(posedge clk) clear_value_select_pin <= 1'b1;
    wt(8);
    chk(clear_to_midscale, 1'b1);
    wrw({3'h5, 2'b00, 4'h6, 3'b000, 4'h0}, 16, 8'h00);
    chk(clear_active, 1'b0);
    @(posedge clk) clear_pin <= 1'b1;
    wt(8);
    chk({clear_active, clear_to_midscale}, 2'b11);
    wrw({3'h5, 2'b00, 4'h1, 3'b000, 4'h0}, 16, 8'h00);
    @(posedge clk) clear_pin <= 1'b0;
    wt(8);
    chk({clear_active, range_code}, {1'b0, 4'h1});
    $display("test clear finished");
    // hardware mode strap driven high here, with range and sense pins
    @(posedge clk) {hardware_mode_pin, range_pins, sense_select_pin} <=
                   {1'b1, 4'h9, 1'b0};
    wt(8);
    chk({range_code, output_enable_bit, sense_resistor_select}, {4'h9, 2'b10});
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) {loop_open_det, volt_short_det, overtemp_det} <= 3'b100 >> i;
      wt(8);
      chk({loop_open_alarm_oe, volt_short_alarm_oe, temp_alarm_oe, fault_alarm_oe},
          {3'b100 >> i, 1'b0});
    end
    rdw(3'h5);
    chk(s, 1'b0);
    $display("test hardware mode finished");
    print_verdict;
  end
endmodule
